// ==== hw/i2cbam_pkg.sv ====
// package of constants and types for the two-wire bus master engine
package i2cbam_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_BITS = 8; // data bits per byte
  localparam logic [3:0] ACK_SLOT = 4'h8; // index of the acknowledge bit
  localparam logic [3:0] LAST_DATA_BIT = 4'h7; // index of the byte's lsb
  localparam logic [6:0] ALT_FMT_ADDR = 7'h02; // address of the alternative bus format
  localparam int unsigned ADDR_MSB = 7; // address field in the first byte
  localparam int unsigned ADDR_LSB = 1;

  // ----------------------------------------------------------------
  // timing, standard-mode figures in ns
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 12; // width of the phase counter
  localparam int unsigned CLK_PERIOD_NS = 20; // local clock period
  localparam int unsigned T_LOW_NS = 4700; // clock low period
  localparam int unsigned T_HIGH_NS = 4000; // clock high period
  localparam int unsigned T_START_HOLD_NS = 4000; // start_hold_time
  localparam int unsigned T_STOP_SETUP_NS = 4000; // stop setup
  localparam int unsigned T_BUS_FREE_NS = 4700; // free time after stop
  localparam int unsigned T_DATA_HOLD_NS = 300; // data change after clock fall

  // least times round up
  localparam logic [CNT_W-1:0] LOW_CYC =
    CNT_W'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HIGH_CYC =
    CNT_W'((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] START_HOLD_CYC =
    CNT_W'((T_START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STOP_SETUP_CYC =
    CNT_W'((T_STOP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BUS_FREE_CYC =
    CNT_W'((T_BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // longest time rounds down
  localparam logic [CNT_W-1:0] DATA_HOLD_CYC = CNT_W'(T_DATA_HOLD_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // commands, answers, states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_START = 3'h0,
    OP_WRITE = 3'h1,
    OP_READ = 3'h2,
    OP_STOP = 3'h3,
    OP_RESTART = 3'h4
  } i2cbam_op_e;

  typedef struct packed {
    i2cbam_op_e op; // what to do
    logic [7:0] data; // byte to send on write
    logic nack_last; // on read: withhold acknowledge
  } i2cbam_cmd_s;

  typedef struct packed {
    logic [7:0] data; // byte seen on the line
    logic nack; // acknowledge slot read high, outside the alternative format
    logic arb_lost; // arbitration lost in this byte
    logic arb_lost_addr; // lost while sending the address
  } i2cbam_rsp_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START_HOLD = 4'h1,
    ST_HOLD = 4'h2,
    ST_BIT_LOW = 4'h3,
    ST_BIT_WAIT = 4'h4,
    ST_BIT_HIGH = 4'h5,
    ST_STOP_LOW = 4'h6,
    ST_STOP_WAIT = 4'h7,
    ST_RS_LOW = 4'h8,
    ST_RS_WAIT = 4'h9
  } i2cbam_state_e;

endpackage

// ==== hw/i2cbam_master.sv ====
// bus master engine: byte framing, acknowledge, clock sync and arbitration
//
// Behaviour
// [R1] eight bits per byte, then acknowledge slot
// [R2] no limit on bytes per transfer
// [R3] bits shifted and sampled msb first
// [R4] wait while receiver holds clock low
// [R5] alternative format: stop mid-byte, no acknowledge
// [R6] master clocks the ninth acknowledge pulse
// [R7] transmitter releases data for acknowledge pulse
// [R8] receiver holds data low through acknowledge high
// [R9] addressed receiver acknowledges except alternative format
// [R10] address not acknowledged, master may stop
// [R11] data not acknowledged, master generates stop
// [R12] master receiver withholds acknowledge on last
// [R13] clock fall restarts low count, hold low
// [R14] wait for clock rise before high count
// [R15] start only while bus is free
// [R16] near-simultaneous starts act as one start
// [R17] released high but seen low: lose
// [R18] arbitrate on address and data bits alike
// [R19] loser clocks only to end of byte
// [R20] address-phase loser switches to slave receiver; the engine only sets arb_lost_addr and goes idle
// [R21] no arbitration against repeated start or stop
// [R22] sample while clock high, change while low
// [R23] data edges with clock high: start, stop
// [R24] busy after start, free after stop
// [R25] lines only pulled low or released
// [R26] start resets byte state, expects address
// [R27] report lost arbitration, not-acknowledge, stop seen
`timescale 1ns/10ps
`default_nettype none

module i2cbam_master #(
  parameter logic [i2cbam_pkg::CNT_W-1:0] LOW_CYC = i2cbam_pkg::LOW_CYC,
  parameter logic [i2cbam_pkg::CNT_W-1:0] HIGH_CYC = i2cbam_pkg::HIGH_CYC,
  parameter logic [i2cbam_pkg::CNT_W-1:0] START_HOLD_CYC = i2cbam_pkg::START_HOLD_CYC,
  parameter logic [i2cbam_pkg::CNT_W-1:0] STOP_SETUP_CYC = i2cbam_pkg::STOP_SETUP_CYC,
  parameter logic [i2cbam_pkg::CNT_W-1:0] BUS_FREE_CYC = i2cbam_pkg::BUS_FREE_CYC,
  parameter logic [i2cbam_pkg::CNT_W-1:0] DATA_HOLD_CYC = i2cbam_pkg::DATA_HOLD_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // command port from local logic
  input wire logic cmd_valid,
  input wire i2cbam_pkg::i2cbam_cmd_s cmd,
  output logic cmd_ready,
  input wire logic alt_stop_req,
  // answers and status to local logic
  output logic rsp_valid,
  output i2cbam_pkg::i2cbam_rsp_s rsp,
  output logic start_seen,
  output logic stop_seen,
  output logic bus_busy,
  // clock line, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // data line, open drain
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic scl_meta_reg; // first synchroniser stage, clock line
  logic scl_s_reg; // synchronised clock line
  logic scl_d_reg; // one cycle older, for edges
  logic sda_meta_reg; // first synchroniser stage, data line
  logic sda_s_reg; // synchronised data line
  logic sda_d_reg; // one cycle older, for edges
  logic start_ev; // start seen on the bus
  logic stop_ev; // stop seen on the bus
  logic scl_fall; // falling clock line
  logic free_cnt_on_reg; // bus-free timer running
  logic [i2cbam_pkg::CNT_W-1:0] free_cnt_reg; // bus-free timer
  i2cbam_pkg::i2cbam_state_e state_reg; // engine state
  logic [i2cbam_pkg::CNT_W-1:0] cnt_reg; // phase counter
  logic [8:0] sh_reg; // bits to put out, msb first
  logic [7:0] rx_reg; // bits sampled, msb first
  logic [3:0] bit_reg; // bit index within the frame
  logic reading_reg; // current byte is read from the slave
  logic first_reg; // next byte is the address
  logic addr_byte_reg; // current byte is the address
  logic alt_reg; // transfer uses the alternative format
  logic lost_reg; // arbitration lost in this byte
  logic take; // command handshake this cycle
  logic hi_done; // high phase ends this cycle
  logic released_low; // our data released but line low

  // ----------------------------------------------------------------
  // synchronisers for the bus lines
  // ----------------------------------------------------------------
  // two flops before any logic looks at a line
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_meta_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_s_reg <= scl_meta_reg;
      sda_meta_reg <= sda_in;
      sda_s_reg <= sda_meta_reg;
    end
  end

  // delayed copies for edge detection
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s_reg;
      sda_d_reg <= sda_s_reg;
    end
  end

  // data edges while clock stays high
  assign start_ev = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg; // [R23]
  assign stop_ev = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg; // [R23]
  assign scl_fall = scl_d_reg & ~scl_s_reg;

  // ----------------------------------------------------------------
  // bus monitor
  // ----------------------------------------------------------------
  // busy from start until the free time after stop has passed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_busy <= 1'b0;
      free_cnt_on_reg <= 1'b0;
      free_cnt_reg <= '0;
    end else if (start_ev) begin
      bus_busy <= 1'b1; // [R24]
      free_cnt_on_reg <= 1'b0;
    end else if (stop_ev) begin
      free_cnt_on_reg <= 1'b1;
      free_cnt_reg <= '0;
    end else if (free_cnt_on_reg) begin
      // a line pulled low again restarts the free time
      if (!(scl_s_reg && sda_s_reg)) begin
        free_cnt_reg <= '0;
      end else if (free_cnt_reg == BUS_FREE_CYC - 1'b1) begin
        bus_busy <= 1'b0; // [R24]
        free_cnt_on_reg <= 1'b0;
      end else begin
        free_cnt_reg <= free_cnt_reg + 1'b1;
      end
    end
  end

  // start and stop status pulses
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      start_seen <= start_ev;
      stop_seen <= stop_ev; // [R27]
    end
  end

  // open drain: the driven level is always low
  always_ff @(posedge clock) begin
    scl_out <= 1'b0; // [R25]
    sda_out <= 1'b0; // [R25]
  end

  // ----------------------------------------------------------------
  // engine helpers
  // ----------------------------------------------------------------
  assign take = cmd_valid & cmd_ready;
  // high phase ends on our own count or when another master pulls low
  assign hi_done = (cnt_reg == HIGH_CYC - 1'b1) | ~scl_s_reg; // [R13]
  assign released_low = ~sda_oe & ~sda_s_reg;

  // ----------------------------------------------------------------
  // engine state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= i2cbam_pkg::ST_IDLE;
      cnt_reg <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      sh_reg <= '0;
      rx_reg <= '0;
      bit_reg <= '0;
      reading_reg <= 1'b0;
      first_reg <= 1'b0;
      addr_byte_reg <= 1'b0;
      alt_reg <= 1'b0;
      lost_reg <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        // bus not owned: both lines released
        i2cbam_pkg::ST_IDLE: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          cmd_ready <= ~bus_busy & ~take; // [R15]
          if (take && cmd.op == i2cbam_pkg::OP_START) begin
            // a start by another master inside our hold merges with ours
            sda_oe <= 1'b1; // [R16]
            cnt_reg <= '0;
            state_reg <= i2cbam_pkg::ST_START_HOLD;
          end
        end
        // data low under high clock, hold the start
        i2cbam_pkg::ST_START_HOLD: begin
          if (cnt_reg == START_HOLD_CYC - 1'b1) begin
            scl_oe <= 1'b1;
            bit_reg <= '0; // [R26]
            first_reg <= 1'b1; // [R26]
            alt_reg <= 1'b0; // [R26]
            lost_reg <= 1'b0;
            cmd_ready <= 1'b1;
            state_reg <= i2cbam_pkg::ST_HOLD;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        // bus owned, clock held low, waiting for the next command
        i2cbam_pkg::ST_HOLD: begin
          scl_oe <= 1'b1;
          cnt_reg <= '0;
          if (take) begin
            cmd_ready <= 1'b0;
            case (cmd.op)
              // byte out, ack slot released
              i2cbam_pkg::OP_WRITE: begin
                sh_reg <= {cmd.data, 1'b1}; // [R7]
                reading_reg <= 1'b0;
                bit_reg <= '0;
                addr_byte_reg <= first_reg;
                first_reg <= 1'b0;
                if (first_reg) begin
                  alt_reg <= (cmd.data[i2cbam_pkg::ADDR_MSB:i2cbam_pkg::ADDR_LSB] ==
                              i2cbam_pkg::ALT_FMT_ADDR); // [R5]
                end
                state_reg <= i2cbam_pkg::ST_BIT_LOW;
              end
              // byte in: data released, ack driven unless last
              i2cbam_pkg::OP_READ: begin
                sh_reg <= {8'hFF, cmd.nack_last}; // [R8] [R12]
                reading_reg <= 1'b1;
                bit_reg <= '0;
                addr_byte_reg <= 1'b0;
                first_reg <= 1'b0;
                state_reg <= i2cbam_pkg::ST_BIT_LOW;
              end
              // end of transfer
              i2cbam_pkg::OP_STOP: begin
                state_reg <= i2cbam_pkg::ST_STOP_LOW;
              end
              // start again without releasing the bus
              default: begin
                state_reg <= i2cbam_pkg::ST_RS_LOW;
              end
            endcase
          end
        end
        // clock low: restart count on each fall, change data late
        i2cbam_pkg::ST_BIT_LOW: begin
          scl_oe <= 1'b1; // [R13]
          if (scl_fall) begin
            cnt_reg <= '0; // [R13]
          end else if (cnt_reg == LOW_CYC - 1'b1) begin
            scl_oe <= 1'b0;
            cnt_reg <= '0;
            state_reg <= i2cbam_pkg::ST_BIT_WAIT;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
          if (cnt_reg == DATA_HOLD_CYC) begin
            sda_oe <= ~sh_reg[8] & ~lost_reg; // [R3] [R22]
          end
        end
        // clock released, wait until it really rises
        i2cbam_pkg::ST_BIT_WAIT: begin
          cnt_reg <= '0;
          if (scl_s_reg) begin
            state_reg <= i2cbam_pkg::ST_BIT_HIGH; // [R4] [R14]
          end
        end
        // clock high: arbitrate, sample at the end
        i2cbam_pkg::ST_BIT_HIGH: begin
          cnt_reg <= cnt_reg + 1'b1;
          // address and data bits alike, acknowledge slot excluded
          if (!reading_reg && bit_reg != i2cbam_pkg::ACK_SLOT && !lost_reg &&
              scl_s_reg && (released_low || start_ev || stop_ev)) begin
            lost_reg <= 1'b1; // [R17] [R18] [R21]
            sda_oe <= 1'b0; // [R17]
          end
          if (hi_done) begin
            scl_oe <= 1'b1;
            cnt_reg <= '0;
            sh_reg <= {sh_reg[7:0], 1'b1}; // [R3]
            bit_reg <= bit_reg + 1'b1; // [R1]
            if (bit_reg != i2cbam_pkg::ACK_SLOT) begin
              rx_reg <= {rx_reg[6:0], sda_s_reg}; // [R3] [R22]
            end
            if (alt_reg && alt_stop_req && !lost_reg) begin
              state_reg <= i2cbam_pkg::ST_STOP_LOW; // [R5]
            end else if (lost_reg && bit_reg == i2cbam_pkg::LAST_DATA_BIT) begin
              // stop clocking at the end of the lost byte
              scl_oe <= 1'b0; // [R19]
              sda_oe <= 1'b0;
              rsp_valid <= 1'b1; // [R27]
              rsp <= '{data: {rx_reg[6:0], sda_s_reg}, nack: 1'b0,
                       arb_lost: 1'b1, arb_lost_addr: addr_byte_reg}; // [R20]
              state_reg <= i2cbam_pkg::ST_IDLE;
            end else if (bit_reg == i2cbam_pkg::ACK_SLOT) begin
              // ninth pulse done: report the byte
              rsp_valid <= 1'b1; // [R6] [R27]
              rsp <= '{data: rx_reg, nack: sda_s_reg & ~alt_reg,
                       arb_lost: 1'b0, arb_lost_addr: 1'b0}; // [R9]
              if (sda_s_reg && !reading_reg && !alt_reg) begin
                state_reg <= i2cbam_pkg::ST_STOP_LOW; // [R10] [R11]
              end else begin
                cmd_ready <= 1'b1; // [R2]
                state_reg <= i2cbam_pkg::ST_HOLD;
              end
            end else begin
              state_reg <= i2cbam_pkg::ST_BIT_LOW;
            end
          end
        end
        // stop: pull data low under low clock
        i2cbam_pkg::ST_STOP_LOW: begin
          scl_oe <= 1'b1;
          if (cnt_reg == DATA_HOLD_CYC) begin
            sda_oe <= 1'b1; // [R22]
          end
          if (cnt_reg == LOW_CYC - 1'b1) begin
            scl_oe <= 1'b0;
            cnt_reg <= '0;
            state_reg <= i2cbam_pkg::ST_STOP_WAIT;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        // stop: clock high for setup, then data rises
        i2cbam_pkg::ST_STOP_WAIT: begin
          cnt_reg <= scl_s_reg ? cnt_reg + 1'b1 : '0; // [R4]
          if (scl_s_reg && cnt_reg == STOP_SETUP_CYC - 1'b1) begin
            sda_oe <= 1'b0; // [R23]
            state_reg <= i2cbam_pkg::ST_IDLE;
          end
        end
        // repeated start: release data under low clock
        i2cbam_pkg::ST_RS_LOW: begin
          scl_oe <= 1'b1;
          if (cnt_reg == DATA_HOLD_CYC) begin
            sda_oe <= 1'b0; // [R22]
          end
          if (cnt_reg == LOW_CYC - 1'b1) begin
            scl_oe <= 1'b0;
            cnt_reg <= '0;
            state_reg <= i2cbam_pkg::ST_RS_WAIT;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        // repeated start: clock high for setup, then data falls
        i2cbam_pkg::ST_RS_WAIT: begin
          cnt_reg <= scl_s_reg ? cnt_reg + 1'b1 : '0; // [R4]
          if (scl_s_reg && cnt_reg == HIGH_CYC - 1'b1) begin
            sda_oe <= 1'b1; // [R23]
            cnt_reg <= '0;
            state_reg <= i2cbam_pkg::ST_START_HOLD;
          end
        end
        default: begin
          state_reg <= i2cbam_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== sim/i2cbam_monitor.sv ====
// assertion checker for the two-wire bus master engine
`timescale 1ns/10ps
`default_nettype none
module i2cbam_monitor #(
  parameter logic [i2cbam_pkg::CNT_W-1:0] LOW_CYC = i2cbam_pkg::LOW_CYC,
  parameter logic [i2cbam_pkg::CNT_W-1:0] HIGH_CYC = i2cbam_pkg::HIGH_CYC,
  parameter logic [i2cbam_pkg::CNT_W-1:0] BUS_FREE_CYC = i2cbam_pkg::BUS_FREE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // status from the engine
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire i2cbam_pkg::i2cbam_rsp_s rsp,
  input wire logic start_seen,
  input wire logic stop_seen,
  input wire logic bus_busy,
  // bus lines
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  // ----------------
  // helper counters
  // ----------------
  logic [15:0] oe_cnt_reg; // cycles we pull the clock
  logic [15:0] hi_cnt_reg; // cycles the clock line is high
  logic [15:0] free_cnt_reg; // cycles both lines are high
  // length of our own low drive
  always_ff @(posedge clock) begin
    oe_cnt_reg <= (sys_rst || !scl_oe) ? 16'h0000 : oe_cnt_reg + 16'h0001;
  end
  // length of the clock high phase
  always_ff @(posedge clock) begin
    hi_cnt_reg <= (sys_rst || !scl_in) ? 16'h0000 : hi_cnt_reg + 16'h0001;
  end
  // idle time on the bus
  always_ff @(posedge clock) begin
    free_cnt_reg <= (sys_rst || !(scl_in && sda_in)) ? 16'h0000 : free_cnt_reg + 16'h0001;
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence s_start_edge;
    scl_in && $fell(sda_in) ##1 scl_in [*3];
  endsequence
  sequence s_stop_edge;
    scl_in && $rose(sda_in) ##1 scl_in [*3];
  endsequence
  sequence s_held_low;
    !scl_oe && !scl_in;
  endsequence
  a_out_low_only: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  a_start_flag: assert property (s_start_edge |-> ##[0:3] start_seen)
    else $error("start not flagged");
  a_stop_flag: assert property (s_stop_edge |-> ##[0:3] stop_seen)
    else $error("stop not flagged");
  a_busy_set: assert property (start_seen |-> ##[0:1] bus_busy)
    else $error("bus not busy after start");
  a_busy_free: assert property ($fell(bus_busy) |-> free_cnt_reg >= 16'(BUS_FREE_CYC))
    else $error("bus freed too early");
  a_low_hold: assert property ($fell(scl_oe) |-> oe_cnt_reg >= 16'(LOW_CYC) - 16'h0001)
    else $error("clock low too short");
  a_high_time: assert property ($rose(scl_oe) && $past(scl_in) |-> hi_cnt_reg >= 16'(HIGH_CYC))
    else $error("clock high too short");
  a_stretch_wait: assert property (s_held_low |=> $stable(sda_oe))
    else $error("data moved while clock held");
  a_lost_idle: assert property (rsp_valid && rsp.arb_lost |-> !scl_oe && !sda_oe)
    else $error("loser still drives");
  a_idle_quiet: assert property (cmd_ready && !bus_busy |-> !scl_oe && !sda_oe)
    else $error("drive while bus free");
endmodule
bind i2cbam_master i2cbam_monitor #(
  .LOW_CYC(LOW_CYC), .HIGH_CYC(HIGH_CYC), .BUS_FREE_CYC(BUS_FREE_CYC)
) u_mon (
  .clock(clock), .sys_rst(sys_rst), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
  .rsp(rsp), .start_seen(start_seen), .stop_seen(stop_seen), .bus_busy(bus_busy),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);
`default_nettype wire

// ==== sim/i2cbam_slave_model.sv ====
// behavioural slave device on the two-wire bus, open drain only
`timescale 1ns/10ps
`default_nettype none
module i2cbam_slave_model #(
  parameter logic [6:0] ADDR = 7'h3A // own address, value arbitrary
) (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull,
  // scenario controls
  input wire logic ack_en,
  input wire logic [7:0] tx_byte,
  input wire logic [31:0] stretch_ns,
  output logic [7:0] rx_byte
);
  int bit_cnt = 0; // bit position, -1 right after start
  logic sel = 1'b0; // we are addressed
  logic rd = 1'b0; // master reads
  logic first = 1'b0; // address byte in flight
  logic [7:0] shift = 8'h00; // incoming bits
  logic [7:0] out = 8'h00; // byte being sent, steps by one
  initial begin
    scl_pull = 1'b0; // lines only pulled or released
    sda_pull = 1'b0;
    rx_byte = 8'h00;
  end
  // start or repeated start resets byte state
  always @(negedge sda) begin
    if (scl) begin
      bit_cnt = -1;
      first = 1'b1;
      sel = 1'b0;
    end
  end
  // sample while clock high, msb first
  always @(posedge scl) begin
    if (bit_cnt >= 0 && bit_cnt < 8) shift = {shift[6:0], sda};
    else if (bit_cnt == 8 && rd && !first && sda) sel = 1'b0;
  end
  // change data only after the clock falls
  always @(negedge scl) begin
    if (bit_cnt == 8) begin // end of acknowledge slot
      out = first ? tx_byte : out + 8'h01;
      bit_cnt = 0;
      first = 1'b0;
      scl_pull = 1'b1; // hold clock while busy
      scl_pull <= #(stretch_ns) 1'b0;
      sda_pull <= #40 sel && rd && !out[7];
    end else begin
      bit_cnt++;
      if (bit_cnt == 8) begin
        rx_byte = shift;
        if (first) begin
          sel = (shift[7:1] == ADDR);
          rd = shift[0];
        end
        // ack own address, writes if willing, never own reads
        sda_pull <= #40 sel && (first || (!rd && ack_en));
      end else begin
        sda_pull <= #40 sel && rd && !first && !out[7-bit_cnt];
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_i2c_byte_ack_arbitration.sv ====
// self-checking bench for the two-wire bus master engine
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_byte_ack_arbitration;
  // ----------------
  // signals
  // ----------------
  localparam logic [6:0] ADDR = 7'h3A; // slave address, arbitrary
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  i2cbam_pkg::i2cbam_cmd_s cmd = '0;
  logic alt_stop_req = 1'b0;
  logic cmd_ready, rsp_valid, start_seen, stop_seen, bus_busy;
  i2cbam_pkg::i2cbam_rsp_s rsp;
  logic scl_out, scl_oe, sda_out, sda_oe, s_scl, s_sda;
  logic tb_sda_pull = 1'b0; // competing master on data
  logic ack_en = 1'b1;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] rx_byte;
  int stretch_ns = 0;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 13;
  int n_start = 0;
  int n_stop = 0;
  // wired-and lines
  wire scl = (!scl_oe || scl_out) && !s_scl;
  wire sda = (!sda_oe || sda_out) && !s_sda && !tb_sda_pull;
  always #10 clock = ~clock;
  i2cbam_master #(.LOW_CYC(12'h00C), .HIGH_CYC(12'h00A), .START_HOLD_CYC(12'h00A),
    .BUS_FREE_CYC(12'h00C), .DATA_HOLD_CYC(12'h002)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .alt_stop_req(alt_stop_req), .rsp_valid(rsp_valid), .rsp(rsp),
    .start_seen(start_seen), .stop_seen(stop_seen), .bus_busy(bus_busy),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  i2cbam_slave_model u_slave (.scl(scl), .sda(sda), .scl_pull(s_scl),
    .sda_pull(s_sda), .ack_en(ack_en), .tx_byte(tx_byte), .stretch_ns(stretch_ns),
    .rx_byte(rx_byte));
  // count bus events away from the edge
  always @(negedge clock) begin
    if (start_seen === 1'b1) n_start++;
    if (stop_seen === 1'b1) n_stop++;
  end
  // ----------------
  // tasks
  // ----------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic issue(input i2cbam_pkg::i2cbam_op_e op, input logic [7:0] d, input logic nl);
    int n;
    logic rdy;
    n = 0;
    @(posedge clock);
    #1 cmd_valid = 1'b1;
    cmd = '{op, d, nl};
    do begin
      @(negedge clock);
      rdy = cmd_ready;
      @(posedge clock);
      n++;
    end while (rdy !== 1'b1 && n < 20000);
    if (rdy !== 1'b1) error_cnt++;
    #1 cmd_valid = 1'b0;
  endtask
  task automatic get_rsp();
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (rsp_valid !== 1'b1 && n < 5000);
    if (rsp_valid !== 1'b1) error_cnt++;
  endtask
  task automatic wr(input logic [7:0] d, input logic nk);
    issue(i2cbam_pkg::OP_WRITE, d, 1'b0);
    get_rsp();
    check(16'(rsp), 16'({d, nk, 2'b00}));
    check(16'(rx_byte), 16'(d));
  endtask
  task automatic rd(input logic nl, input logic [7:0] exp);
    issue(i2cbam_pkg::OP_READ, 8'h00, nl);
    get_rsp();
    check(16'(rsp.data), 16'(exp));
  endtask
  // ----------------
  // scenarios
  // ----------------
  initial begin
    #2_000_000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clock);
    #1 sys_rst = 1'b0;
    // write with stretched clock, random bytes, refused last byte
    stretch_ns = 700;
    issue(i2cbam_pkg::OP_START, 8'h00, 1'b0);
    wr({ADDR, 1'b0}, 1'b0);
    repeat (3) wr(8'($random(seed)), 1'b0);
    ack_en = 1'b0;
    wr(8'($random(seed)), 1'b1);
    ack_en = 1'b1;
    stretch_ns = 0;
    // address nobody owns
    issue(i2cbam_pkg::OP_START, 8'h00, 1'b0);
    wr({7'h11, 1'b0}, 1'b1);
    // write, repeated start, read two bytes, last unacknowledged
    tx_byte = 8'($random(seed));
    issue(i2cbam_pkg::OP_START, 8'h00, 1'b0);
    wr({ADDR, 1'b0}, 1'b0);
    wr(8'($random(seed)), 1'b0);
    issue(i2cbam_pkg::OP_RESTART, 8'h00, 1'b0);
    wr({ADDR, 1'b1}, 1'b0);
    rd(1'b0, tx_byte);
    rd(1'b1, tx_byte + 8'h01);
    issue(i2cbam_pkg::OP_STOP, 8'h00, 1'b0);
    // alternative format message, no acknowledge reported
    issue(i2cbam_pkg::OP_START, 8'h00, 1'b0);
    wr({i2cbam_pkg::ALT_FMT_ADDR, 1'b0}, 1'b0);
    wr(8'hC3, 1'b0);
    // local request cuts the next byte short with a stop
    @(posedge clock);
    #1 alt_stop_req = 1'b1;
    issue(i2cbam_pkg::OP_WRITE, 8'h5A, 1'b0);
    do @(negedge clock); while (stop_seen !== 1'b1);
    @(posedge clock);
    #1 alt_stop_req = 1'b0;
    // other master holds data low through our address
    issue(i2cbam_pkg::OP_START, 8'h00, 1'b0);
    do @(negedge clock); while (cmd_ready !== 1'b1);
    @(posedge clock);
    #1 tb_sda_pull = 1'b1;
    issue(i2cbam_pkg::OP_WRITE, 8'hC0, 1'b0);
    get_rsp();
    check(16'({rsp.arb_lost, rsp.arb_lost_addr}), 16'h0003);
    repeat (5) @(posedge clock);
    #1 tb_sda_pull = 1'b0;
    repeat (100) @(posedge clock);
    check(16'(bus_busy), 16'h0000);
    check(16'(n_start), 16'h0006);
    check(16'(n_stop), 16'h0005);
    end_sim();
  end
endmodule
`default_nettype wire
